// File: design/fault_status_regs.sv
// Purpose: fault mask and device status registers of the spi bridge
// Assumes: register accesses arrive decoded from spi frames on i_clk_sys
// Notes: fault pin is open drain, driven low while the error flag is set
module fault_status_regs
   import fault_status_pkg::*;
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // register access from the spi command decoder
   input wire logic i_reg_wr_en,
   input wire logic i_reg_rd_en,
   input wire logic [ADDR_W-1:0] i_reg_addr,
   input wire logic [DATA_W-1:0] i_reg_wdata,
   output logic [DATA_W-1:0] o_reg_rdata,
   output logic o_reg_rvalid,
   // fault events, one-cycle pulses
   input wire logic i_evt_chain_checkbit,
   input wire logic i_evt_chain_crc,
   input wire logic i_evt_chain_stuck,
   input wire logic i_evt_chain_other,
   input wire logic i_evt_spi_crc,
   input wire logic i_evt_spi_if,
   input wire logic i_evt_txff,
   input wire logic i_evt_rxff,
   input wire logic i_evt_otp_crc,
   input wire logic i_evt_osc_range,
   // chain link and device state
   input wire logic i_chain_tx_busy,
   input wire logic i_chain_rx_busy,
   input wire logic i_soft_reset_req,
   input wire logic [1:0] i_device_state_field,
   output logic o_soft_reset_go,
   output logic o_chain_ctrl_wr,
   output logic [DATA_W-1:0] o_chain_ctrl_wdata,
   // pins
   input wire logic i_data_ready_pin,
   output logic o_fault_pin_out,
   output logic o_fault_pin_oe
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   flag_bank_if fb();

   logic [DATA_W-1:0] mask_ff;
   logic err_ff;
   logic fault_oe_ff;
   logic fault_out_ff;
   logic data_ready_meta_ff;
   logic data_ready_sync_ff;
   logic [DATA_W-1:0] rdata_ff;
   logic rvalid_ff;
   logic soft_reset_go_ff;
   logic chain_ctrl_wr_ff;
   logic [DATA_W-1:0] chain_ctrl_wdata_ff;

   logic wr_mask;
   logic wr_status;
   logic wr_chain_ctrl;
   logic clear_all;
   logic chain_busy;
   logic srst_refused_evt;
   logic reg_wr_rej_evt;
   logic [NUM_FLAGS-1:0] flags;
   logic chain_err;
   logic unmasked_class;
   logic other_err;
   logic nxt_err;
   logic [DATA_W-1:0] status_word;
   logic [DATA_W-1:0] nxt_rdata;

   // ----------------------------------------------------------------
   // address decode
   // ----------------------------------------------------------------
   assign wr_mask = i_reg_wr_en && (i_reg_addr == ADDR_FAULT_MASK);
   assign wr_status = i_reg_wr_en && (i_reg_addr == ADDR_DEVICE_STATUS);
   assign wr_chain_ctrl = i_reg_wr_en && (i_reg_addr == ADDR_CHAIN_LINK_CTRL);
   assign clear_all = wr_status && i_reg_wdata[ST_CLEAR_ALL_BIT];
   assign chain_busy = i_chain_tx_busy || i_chain_rx_busy;

   // soft reset is only blocked by transmission, not by reception
   assign srst_refused_evt = i_soft_reset_req && i_chain_tx_busy;
   assign reg_wr_rej_evt = wr_chain_ctrl && chain_busy;

   // ----------------------------------------------------------------
   // sticky flags
   // ----------------------------------------------------------------
   assign fb.clear = clear_all;
   assign fb.set[F_CHAIN_CHECKBIT] = i_evt_chain_checkbit;
   assign fb.set[F_CHAIN_CRC] = i_evt_chain_crc;
   assign fb.set[F_CHAIN_STUCK] = i_evt_chain_stuck;
   assign fb.set[F_CHAIN_OTHER] = i_evt_chain_other;
   assign fb.set[F_SPI_CRC] = i_evt_spi_crc;
   assign fb.set[F_SPI_IF] = i_evt_spi_if;
   assign fb.set[F_TXFF] = i_evt_txff;
   assign fb.set[F_RXFF] = i_evt_rxff;
   assign fb.set[F_OTP_CRC] = i_evt_otp_crc;
   assign fb.set[F_OSC] = i_evt_osc_range;
   assign fb.set[F_SRST_REFUSED] = srst_refused_evt;
   assign fb.set[F_REG_WR_REJ] = reg_wr_rej_evt;
   // power-on only, set by reset value of the bank
   assign fb.set[F_POR] = 1'b0;
   assign flags = fb.flags;

   sticky_flag_bank u_flags (
      .i_clk_sys(i_clk_sys),
      .i_rstn(i_rstn),
      .fb(fb)
   );

   // ----------------------------------------------------------------
   // global error and fault pin
   // ----------------------------------------------------------------
   assign chain_err = flags[F_CHAIN_CHECKBIT] || flags[F_CHAIN_CRC] ||
      flags[F_CHAIN_STUCK] || flags[F_CHAIN_OTHER];
   assign unmasked_class =
      (flags[F_CHAIN_CHECKBIT] && !mask_ff[MASK_CHAIN_CHECKBIT_BIT]) ||
      (flags[F_CHAIN_CRC] && !mask_ff[MASK_CHAIN_CRC_BIT]) ||
      (flags[F_CHAIN_STUCK] && !mask_ff[MASK_CHAIN_STUCK_BIT]) ||
      (flags[F_SPI_CRC] && !mask_ff[MASK_SPI_CRC_BIT]);
   // refusals are host mistakes, not device faults, so they stay off the pin
   assign other_err = flags[F_CHAIN_OTHER] || flags[F_SPI_IF] ||
      flags[F_TXFF] || flags[F_RXFF] || flags[F_OTP_CRC] ||
      flags[F_OSC] || flags[F_POR];
   assign nxt_err = unmasked_class || other_err;

   // both flops share one next value so bit 0 never disagrees with the pin
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         err_ff <= DEVICE_STATUS_RST[ST_GLOBAL_ERR_BIT];
         fault_oe_ff <= DEVICE_STATUS_RST[ST_GLOBAL_ERR_BIT];
         fault_out_ff <= 1'b0;
      end else begin
         err_ff <= nxt_err;
         fault_oe_ff <= nxt_err;
         fault_out_ff <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // fault mask register
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         mask_ff <= FAULT_MASK_RST;
      end else if (wr_mask) begin
         mask_ff <= i_reg_wdata;
      end
   end

   // ----------------------------------------------------------------
   // data-ready pin synchroniser
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         data_ready_meta_ff <= DEVICE_STATUS_RST[ST_DATA_READY_BIT];
         data_ready_sync_ff <= DEVICE_STATUS_RST[ST_DATA_READY_BIT];
      end else begin
         data_ready_meta_ff <= i_data_ready_pin;
         data_ready_sync_ff <= data_ready_meta_ff;
      end
   end

   // ----------------------------------------------------------------
   // status word and read path
   // ----------------------------------------------------------------
   always_comb begin
      status_word = '0;
      status_word[ST_CHAIN_ERR_BIT] = chain_err;
      status_word[ST_TXFF_ERR_BIT] = flags[F_TXFF];
      status_word[ST_RXFF_ERR_BIT] = flags[F_RXFF];
      status_word[ST_DATA_READY_BIT] = data_ready_sync_ff;
      status_word[ST_SRST_REFUSED_BIT] = flags[F_SRST_REFUSED];
      status_word[ST_SPI_ERR_BIT] = flags[F_SPI_IF] || flags[F_SPI_CRC];
      status_word[ST_REG_WR_REJ_BIT] = flags[F_REG_WR_REJ];
      status_word[ST_SPI_CRC_BIT] = flags[F_SPI_CRC];
      status_word[ST_STATE_LSB+1 -: 2] = i_device_state_field;
      status_word[ST_OTP_CRC_BIT] = flags[F_OTP_CRC];
      status_word[ST_OSC_BIT] = flags[F_OSC];
      status_word[ST_POR_BIT] = flags[F_POR];
      status_word[ST_GLOBAL_ERR_BIT] = err_ff;
   end

   // clear-all bit always reads zero; unmapped indices read zero
   assign nxt_rdata = (i_reg_addr == ADDR_FAULT_MASK) ? mask_ff :
      (i_reg_addr == ADDR_DEVICE_STATUS) ? status_word : '0;

   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         rdata_ff <= '0;
         rvalid_ff <= 1'b0;
      end else begin
         rvalid_ff <= i_reg_rd_en;
         if (i_reg_rd_en) begin
            rdata_ff <= nxt_rdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // soft reset and chain control write gating
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk_sys or negedge i_rstn) begin
      if (!i_rstn) begin
         soft_reset_go_ff <= 1'b0;
         chain_ctrl_wr_ff <= 1'b0;
         chain_ctrl_wdata_ff <= '0;
      end else begin
         soft_reset_go_ff <= i_soft_reset_req && !i_chain_tx_busy;
         chain_ctrl_wr_ff <= wr_chain_ctrl && !chain_busy;
         if (wr_chain_ctrl && !chain_busy) begin
            chain_ctrl_wdata_ff <= i_reg_wdata;
         end
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_reg_rdata = rdata_ff;
   assign o_reg_rvalid = rvalid_ff;
   assign o_soft_reset_go = soft_reset_go_ff;
   assign o_chain_ctrl_wr = chain_ctrl_wr_ff;
   assign o_chain_ctrl_wdata = chain_ctrl_wdata_ff;
   assign o_fault_pin_out = fault_out_ff;
   assign o_fault_pin_oe = fault_oe_ff;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rstn);

   AST_CHECKBIT_REPORTS: assert property (
      (flags[F_CHAIN_CHECKBIT] && !mask_ff[MASK_CHAIN_CHECKBIT_BIT])
      |=> (err_ff && o_fault_pin_oe))
      else $error("unmasked check-bit fault did not raise error");
   AST_CHAIN_CRC_REPORTS: assert property (
      (flags[F_CHAIN_CRC] && !mask_ff[MASK_CHAIN_CRC_BIT])
      |=> (err_ff && o_fault_pin_oe))
      else $error("unmasked chain crc fault did not raise error");
   AST_STUCK_REPORTS: assert property (
      (flags[F_CHAIN_STUCK] && !mask_ff[MASK_CHAIN_STUCK_BIT])
      |=> (err_ff && o_fault_pin_oe))
      else $error("unmasked stuck fault did not raise error");
   AST_SPI_CRC_REPORTS: assert property (
      (flags[F_SPI_CRC] && !mask_ff[MASK_SPI_CRC_BIT]) |=> err_ff)
      else $error("unmasked spi crc fault did not raise error");
   AST_MASKED_SILENT: assert property (
      (flags == (NUM_FLAGS'(1) << F_CHAIN_CRC) &&
       mask_ff[MASK_CHAIN_CRC_BIT]) |=> (!err_ff && !o_fault_pin_oe))
      else $error("masked fault reached the error flag");
   AST_MASK_WRITE: assert property (
      wr_mask |=> (mask_ff == $past(i_reg_wdata)))
      else $error("fault mask write not stored");
   AST_CLEAR_ALL: assert property (
      (clear_all && fb.set == '0) |=> (flags == '0))
      else $error("clear-all left a flag set");
   AST_DATA_READY_MIRROR: assert property (
      1'b1 |-> ##2 (status_word[ST_DATA_READY_BIT] ==
      $past(i_data_ready_pin, 2)))
      else $error("data-ready status lags pin wrongly");
   AST_SRST_REFUSED: assert property (
      (i_soft_reset_req && i_chain_tx_busy)
      |=> (flags[F_SRST_REFUSED] && !o_soft_reset_go))
      else $error("soft reset not refused while transmitting");
   AST_CHAIN_WR_REJECT: assert property (
      (wr_chain_ctrl && chain_busy)
      |=> (flags[F_REG_WR_REJ] && !o_chain_ctrl_wr))
      else $error("chain control write not rejected");
   AST_PIN_INVERSE: assert property (
      o_reg_rvalid && $past(i_reg_addr) == ADDR_DEVICE_STATUS
      |-> o_reg_rdata[ST_GLOBAL_ERR_BIT] == $past(o_fault_pin_oe))
      else $error("global error flag disagrees with fault pin");
   // a clear or a mask change one cycle back may legally drop the flag
   AST_ERR_HOLDS: assert property (
      (err_ff && !$past(clear_all) && $stable(mask_ff)) |=> err_ff)
      else $error("error flag dropped without a clear");

   COV_MASKED_FAULT: cover property (
      i_evt_chain_stuck && mask_ff[MASK_CHAIN_STUCK_BIT]);
   COV_CLEAR_AFTER_FAULT: cover property (
      err_ff ##1 clear_all ##2 !err_ff);
   COV_SRST_REFUSED: cover property (srst_refused_evt);
   COV_FAILSAFE_READ: cover property (
      o_reg_rvalid && i_device_state_field == STATE_FAILSAFE);

endmodule // fault_status_regs

// File: design/fault_status_pkg.sv
// Purpose: constants shared by the fault mask and status register bank
// Assumes: 16-bit registers reached by a register index from the spi decoder
// Notes: flag indices pick positions in the sticky flag bank
package fault_status_pkg;

   // ----------------------------------------------------------------
   // register map
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 4;
   localparam int unsigned DATA_W = 16;
   localparam logic [3:0] ADDR_CHAIN_LINK_CTRL = 4'h2;
   localparam logic [3:0] ADDR_FAULT_MASK = 4'h6;
   localparam logic [3:0] ADDR_DEVICE_STATUS = 4'h7;
   localparam logic [15:0] FAULT_MASK_RST = 16'h0000;
   localparam logic [15:0] DEVICE_STATUS_RST = 16'h0403;

   // ----------------------------------------------------------------
   // fault_report_mask fields
   // ----------------------------------------------------------------
   localparam int unsigned MASK_CHAIN_CHECKBIT_BIT = 11;
   localparam int unsigned MASK_CHAIN_CRC_BIT = 9;
   localparam int unsigned MASK_CHAIN_STUCK_BIT = 8;
   localparam int unsigned MASK_SPI_CRC_BIT = 0;

   // ----------------------------------------------------------------
   // device_status fields
   // ----------------------------------------------------------------
   localparam int unsigned ST_CLEAR_ALL_BIT = 15;
   localparam int unsigned ST_CHAIN_ERR_BIT = 14;
   localparam int unsigned ST_TXFF_ERR_BIT = 12;
   localparam int unsigned ST_RXFF_ERR_BIT = 11;
   localparam int unsigned ST_DATA_READY_BIT = 10;
   localparam int unsigned ST_SRST_REFUSED_BIT = 9;
   localparam int unsigned ST_SPI_ERR_BIT = 8;
   localparam int unsigned ST_REG_WR_REJ_BIT = 7;
   localparam int unsigned ST_SPI_CRC_BIT = 6;
   localparam int unsigned ST_STATE_LSB = 4;
   localparam int unsigned ST_OTP_CRC_BIT = 3;
   localparam int unsigned ST_OSC_BIT = 2;
   localparam int unsigned ST_POR_BIT = 1;
   localparam int unsigned ST_GLOBAL_ERR_BIT = 0;
   localparam logic [1:0] STATE_NORMAL = 2'h0;
   localparam logic [1:0] STATE_FAILSAFE = 2'h3;

   // ----------------------------------------------------------------
   // sticky flag indices
   // ----------------------------------------------------------------
   localparam int unsigned NUM_FLAGS = 13;
   localparam int unsigned F_CHAIN_CHECKBIT = 0;
   localparam int unsigned F_CHAIN_CRC = 1;
   localparam int unsigned F_CHAIN_STUCK = 2;
   localparam int unsigned F_CHAIN_OTHER = 3;
   localparam int unsigned F_SPI_CRC = 4;
   localparam int unsigned F_SPI_IF = 5;
   localparam int unsigned F_TXFF = 6;
   localparam int unsigned F_RXFF = 7;
   localparam int unsigned F_OTP_CRC = 8;
   localparam int unsigned F_OSC = 9;
   localparam int unsigned F_SRST_REFUSED = 10;
   localparam int unsigned F_REG_WR_REJ = 11;
   localparam int unsigned F_POR = 12;
   localparam logic [12:0] FLAG_RST = 13'h1000;

endpackage

// File: design/flag_bank_if.sv
// Purpose: carries set, clear and state of the sticky flag bank
// Assumes: one clock, same domain on both sides
// Notes: set and clear are one-cycle pulses
interface flag_bank_if;
   import fault_status_pkg::*;
   logic [NUM_FLAGS-1:0] set;
   logic clear;
   logic [NUM_FLAGS-1:0] flags;
   modport owner(output set, output clear, input flags);
   modport bank(input set, input clear, output flags);
endinterface

// File: design/sticky_flag_bank.sv
// Purpose: bank of sticky error flags with a common clear
// Assumes: set and clear come from logic on i_clk_sys
// Notes: a set in the clear cycle wins, so no event is lost
module sticky_flag_bank
   import fault_status_pkg::*;
(
   // clock and reset
   input wire logic i_clk_sys,
   input wire logic i_rstn,
   // flag carrier
   flag_bank_if.bank fb
);

   logic [NUM_FLAGS-1:0] flag_ff;
   logic [NUM_FLAGS-1:0] nxt_flag;

   // ----------------------------------------------------------------
   // per-flag storage
   // ----------------------------------------------------------------
   assign nxt_flag = fb.set | (flag_ff & ~{NUM_FLAGS{fb.clear}});
   assign fb.flags = flag_ff;

   for (genvar i = 0; i < NUM_FLAGS; i++) begin : g_flag
      always_ff @(posedge i_clk_sys or negedge i_rstn) begin
         if (!i_rstn) begin
            flag_ff[i] <= FLAG_RST[i];
         end else begin
            flag_ff[i] <= nxt_flag[i];
         end
      end
   end

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   AST_FLAG_STICKY: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (!fb.clear) [*2] |-> $past(flag_ff) == (flag_ff & $past(flag_ff)))
      else $error("a sticky flag fell without a clear");
   AST_SET_WINS: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
      (fb.clear && fb.set != '0) |=> (flag_ff & $past(fb.set)) == $past(fb.set))
      else $error("set lost against clear");

endmodule // sticky_flag_bank

// File: testbench/reg_host_model.sv
// Purpose: host model issuing register reads and writes to the bank
// Assumes: one-cycle request pulses, read answer within a few cycles
// Notes: released address and data show the inverse of the last value
module reg_host_model
   import fault_status_pkg::*;
(
   // clock
   input wire logic i_clk_sys,
   // register access
   output logic o_wr,
   output logic o_rd,
   output logic [ADDR_W-1:0] o_addr,
   output logic [DATA_W-1:0] o_wdata,
   input wire logic [DATA_W-1:0] i_rdata,
   input wire logic i_rvalid
);
   timeunit 1ns;
   timeprecision 100ps;

   initial begin
      o_wr = 1'h0;
      o_rd = 1'h0;
      o_addr = 4'h0;
      o_wdata = 16'h0000;
   end

   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(negedge i_clk_sys);
      o_addr = a;
      o_wdata = d;
      o_wr = 1'h1;
      @(negedge i_clk_sys);
      o_wr = 1'h0;
      o_addr = ~a;
      o_wdata = ~d;
   endtask

   // bounded wait: a missing answer returns ok low instead of hanging
   task automatic rd(input logic [3:0] a, output logic [15:0] d,
                     output bit ok);
      ok = 1'b0;
      d = 16'h0000;
      @(negedge i_clk_sys);
      o_addr = a;
      o_rd = 1'h1;
      @(negedge i_clk_sys);
      o_rd = 1'h0;
      o_addr = ~a;
      for (int i = 0; i < 4 && !ok; i++) begin
         if (i_rvalid === 1'b1) begin
            d = i_rdata;
            ok = 1'b1;
         end else begin
            @(negedge i_clk_sys);
         end
      end
   endtask
endmodule // reg_host_model

// File: testbench/tb.sv
// Purpose: self-checking bench for the fault mask and status bank
// Assumes: inputs change on the falling edge of i_clk_sys
// Notes: event table first, then reset and refusal cases by hand
module tb;
   import fault_status_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   typedef struct {int evt; logic [15:0] mask; logic [15:0] exp;} row_t;
   logic clk = 1'h0, rstn = 1'h0, wr, rd_en, rv, go, cwr, oe, pout;
   logic data_ready_pin = 1'h1, txb = 1'h0, rxb = 1'h0, srst = 1'h0;
   logic [9:0] evt = 10'h000;
   logic [1:0] st = 2'h0;
   logic [3:0] addr;
   logic [15:0] wdata, rdata, cwdata, d;
   int error_cnt = 0, total_checks = 0, go_cnt = 0, cwr_cnt = 0;
   row_t rows[14] = '{
      '{0, 16'hf7ff, 16'h4401}, '{0, 16'h0800, 16'h4400},
      '{1, 16'hfdff, 16'h4401}, '{1, 16'h0200, 16'h4400},
      '{2, 16'hfeff, 16'h4401}, '{2, 16'h0100, 16'h4400},
      '{3, 16'hffff, 16'h4401}, '{5, 16'hffff, 16'h0501},
      '{4, 16'hfffe, 16'h0541}, '{4, 16'h0001, 16'h0540},
      '{6, 16'hffff, 16'h1401}, '{7, 16'hffff, 16'h0c01},
      '{8, 16'hffff, 16'h0409}, '{9, 16'hffff, 16'h0405}};

   always #5 clk = ~clk;
   always @(posedge clk) begin
      if (go === 1'b1) go_cnt++;
      if (cwr === 1'b1) cwr_cnt++;
   end

   reg_host_model host (.i_clk_sys(clk), .o_wr(wr), .o_rd(rd_en),
      .o_addr(addr), .o_wdata(wdata), .i_rdata(rdata), .i_rvalid(rv));
   fault_status_regs dut (.i_clk_sys(clk), .i_rstn(rstn),
      .i_reg_wr_en(wr), .i_reg_rd_en(rd_en), .i_reg_addr(addr),
      .i_reg_wdata(wdata), .o_reg_rdata(rdata), .o_reg_rvalid(rv),
      .i_evt_chain_checkbit(evt[0]), .i_evt_chain_crc(evt[1]),
      .i_evt_chain_stuck(evt[2]), .i_evt_chain_other(evt[3]),
      .i_evt_spi_crc(evt[4]), .i_evt_spi_if(evt[5]), .i_evt_txff(evt[6]),
      .i_evt_rxff(evt[7]), .i_evt_otp_crc(evt[8]), .i_evt_osc_range(evt[9]),
      .i_chain_tx_busy(txb), .i_chain_rx_busy(rxb),
      .i_soft_reset_req(srst), .i_device_state_field(st), .o_soft_reset_go(go),
      .o_chain_ctrl_wr(cwr), .o_chain_ctrl_wdata(cwdata),
      .i_data_ready_pin(data_ready_pin), .o_fault_pin_out(pout),
      .o_fault_pin_oe(oe));

   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] e,
                      input logic [15:0] g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("mismatch %s exp %h got %h", nm, e, g);
      end
   endtask

   // a read that never answers ends the run
   task automatic rd(input logic [3:0] a, output logic [15:0] v);
      bit ok;
      host.rd(a, v, ok);
      if (!ok) begin
         error_cnt++;
         $display("mismatch rvalid exp 1 got 0");
         print_verdict();
      end
   endtask

   task automatic pulse(input int i);
      @(negedge clk);
      evt[i] = 1'h1;
      @(negedge clk);
      evt[i] = 1'h0;
      repeat (3) @(negedge clk);
   endtask

   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (4) @(negedge clk);
      rstn = 1'h1;
      foreach (rows[i]) begin
         host.wr(ADDR_FAULT_MASK, rows[i].mask);
         rd(ADDR_FAULT_MASK, d);
         chk("mask", rows[i].mask, d);
         host.wr(ADDR_DEVICE_STATUS, 16'h8000);
         pulse(rows[i].evt);
         rd(ADDR_DEVICE_STATUS, d);
         chk("flags", rows[i].exp & 16'hfffe, d & 16'hfffe);
         chk("err_bit", {15'h0, rows[i].exp[0]}, {15'h0, d[0]});
         chk("pin_oe", {15'h0, rows[i].exp[0]}, {15'h0, oe});
         chk("pin_oe_cls", 16'h0001, {15'h0, d[0] ~^ oe});
         chk("pin_out", 16'h0000, {15'h0, pout});
      end
      $display("done: event table");
      @(negedge clk);
      rstn = 1'h0;
      repeat (4) @(negedge clk);
      rstn = 1'h1;
      rd(ADDR_FAULT_MASK, d);
      chk("mask_rst", FAULT_MASK_RST, d);
      rd(ADDR_DEVICE_STATUS, d);
      chk("status_rst", DEVICE_STATUS_RST, d);
      chk("oe_rst", 16'h0001, {15'h0, oe});
      host.wr(ADDR_DEVICE_STATUS, 16'h7fff);
      rd(ADDR_DEVICE_STATUS, d);
      chk("no_clear", 16'h0403, d);
      host.wr(ADDR_DEVICE_STATUS, 16'h8000);
      rd(ADDR_DEVICE_STATUS, d);
      chk("cleared", 16'h0400, d);
      chk("oe_clear", 16'h0000, {15'h0, oe});
      $display("done: reset and clear");
      data_ready_pin = 1'h0;
      repeat (3) @(negedge clk);
      rd(ADDR_DEVICE_STATUS, d);
      chk("data_ready_pin_low", 16'h0000, d);
      data_ready_pin = 1'h1;
      for (int s = 0; s < 4; s++) begin
         st = s[1:0];
         repeat (3) @(negedge clk);
         rd(ADDR_DEVICE_STATUS, d);
         chk("state", 16'h0400 | (16'(s) << 4), d);
      end
      st = 2'h0;
      $display("done: pin level and state");
      srst = 1'h1;
      @(negedge clk);
      srst = 1'h0;
      txb = 1'h1;
      repeat (2) @(negedge clk);
      chk("srst_go", 16'h0001, 16'(go_cnt));
      srst = 1'h1;
      @(negedge clk);
      srst = 1'h0;
      repeat (2) @(negedge clk);
      txb = 1'h0;
      chk("srst_refused", 16'h0001, 16'(go_cnt));
      rd(ADDR_DEVICE_STATUS, d);
      chk("srst_flag", 16'h0600, d);
      host.wr(ADDR_DEVICE_STATUS, 16'h8000);
      rxb = 1'h1;
      host.wr(ADDR_CHAIN_LINK_CTRL, 16'h00a5);
      rxb = 1'h0;
      rd(ADDR_DEVICE_STATUS, d);
      chk("wr_rej_flag", 16'h0480, d);
      chk("wr_rej", 16'h0000, 16'(cwr_cnt));
      host.wr(ADDR_CHAIN_LINK_CTRL, 16'h005a);
      @(negedge clk);
      chk("wr_ok", 16'h0001, 16'(cwr_cnt));
      chk("wr_data", 16'h005a, cwdata);
      fork
         host.wr(ADDR_DEVICE_STATUS, 16'h8000);
         pulse(9);
      join
      rd(ADDR_DEVICE_STATUS, d);
      chk("set_wins", 16'h0405, d);
      rd(4'hf, d);
      chk("unmapped", 16'h0000, d);
      $display("done: refusals and unmapped read");
      print_verdict();
   end
endmodule // tb
